// >>> design/timer_ctrl_defines.vh
// constants of the timer control and master trigger block
// Overview of operation
// - no edge-to-center alignment change while running
// - alignment 00 edge, 01 down, 10 up, 11 both
// - direction writable only in edge, non-quadrature mode
// - single pulse stops counter at update event
// - source 0: request, overflow, restart raise update
// - source 1: only overflow or underflow raises update request
// - inhibit 0: update event loads buffered registers
// - inhibit 1: no update, request still reinitializes
// - complementary output idles at its bit level
// - main output idles after dead-time if it has a complement; protect 00
// - idle bits at 8..14, channel 3 no complement
// - bit 7 picks chan0 pin or xor of three
// - trigger 000: pulse on request or slave reset
// - trigger 001: follows counter enable
// - trigger 010: update event
// - trigger 011: channel 0 capture/compare pulse
// - trigger 100..111: compare references 0..3
`ifndef TIMER_CTRL_DEFINES_VH
`define TIMER_CTRL_DEFINES_VH
`define OFS_COUNTER_CONTROL   12'h000
`define OFS_IDLE_TRIG_CONTROL 12'h004
`define OFS_CONTROL2          12'h008
`define OFS_IRQ_STATUS        12'h00c
`define OFS_IRQ_CLEAR         12'h010
`define OFS_IRQ_ENABLE        12'h014
`define RST_COUNTER_CONTROL   32'h00000000
`define RST_IDLE_TRIG_CONTROL 32'h00000000
`define RST_CONTROL2          32'h00000000
`define MASK_COUNTER_CONTROL  32'h0000007f
`define MASK_IDLE_TRIG        32'h00007ff0
`define MASK_CONTROL2         32'h000000f3
`define BIT_RUN               0
`define BIT_INHIBIT           1
`define BIT_SOURCE            2
`define BIT_SINGLE            3
`define BIT_DIR               4
`define ALIGN_LO              5
`define ALIGN_HI              6
`define TRIG_LO               4
`define TRIG_HI               6
`define BIT_TRIG_IN_SEL       7
`define IDLE_LO               8
`define IDLE_HI               14
`define BIT_POE               0
`define BIT_SYNC              1
`define PROTECT_LEVEL_LO               4
`define PROTECT_LEVEL_HI               5
`define BIT_QUAD              6
`define BIT_PAUSE             7
`define ALIGN_EDGE            2'h0
`define PROTECT_LEVEL_OPEN             2'h0
`define TRIG_RESET            3'h0
`define TRIG_ENABLE           3'h1
`define TRIG_UPDATE           3'h2
`define TRIG_CAPCMP           3'h3
`define TRIG_OC0              3'h4
`define TRIG_OC1              3'h5
`define TRIG_OC2              3'h6
`define TRIG_OC3              3'h7
`define DEAD_TIME_NS          80
`define CLK_PERIOD_NS         40
`define DEAD_CYCLES ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_UPDATE            0
`define IRQ_TRIGGER           1
`define IRQ_STOP              2
`endif

// >>> design/idle_delay.v
// per-channel dead-time delay toward the idle level of a main output
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_defines.vh"
module idle_delay (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       go_idle,
  input  wire       has_compl,
  output reg        idle_now
);
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;

  // dead-time count kept as a full word; only its low bits meet the counter
  localparam [31:0] dead_word = `DEAD_CYCLES;

  always @* begin
    cnt_next = cnt_reg;
    if (!go_idle) begin
      cnt_next = 4'h0;
    end else if (cnt_reg != 4'hf) begin
      cnt_next = cnt_reg + 4'h1;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 4'h0;
      idle_now <= 1'b1;
    end else begin
      cnt_reg <= cnt_next;
      // main output waits out the dead-time only if a complement exists
      if (!go_idle) begin
        idle_now <= 1'b0;
      end else if (!has_compl) begin
        idle_now <= 1'b1;
      end else if (cnt_next >= dead_word[3:0]) begin
        idle_now <= 1'b1;
      end
    end
  end
endmodule // idle_delay
`default_nettype wire

// >>> design/timer_ctrl.v
// control registers, output idle levels and master trigger selection
`timescale 1ns/1ps
`default_nettype none
`include "timer_ctrl_defines.vh"
module timer_ctrl (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        overflow_event,
  input  wire        slave_restart,
  input  wire        pause_trigger_in,
  input  wire        hw_dir_down,
  input  wire        chan0_capcmp_event,
  input  wire [3:0]  compare_ref,
  input  wire [3:0]  chan_active_out,
  input  wire [2:0]  compl_active_out,
  input  wire [2:0]  chan_pins,
  output reg         counter_run,
  output reg         count_down,
  output reg  [1:0]  align_mode,
  output reg         update_event,
  output reg         update_request,
  output reg         counter_reinit,
  output reg         trigger_output,
  output reg         chan0_trigger_in,
  output reg  [3:0]  chan_primary_output,
  output reg  [2:0]  chan_complementary_output,
  output reg         irq
);
  reg [31:0] ctl0_reg;
  reg [31:0] ctl1_reg;
  reg [31:0] ctl2_reg;
  reg [2:0]  stat_reg;
  reg [2:0]  ien_reg;
  reg        sw_req_reg;
  reg        restart_d_reg;
  reg        pause_d_reg;

  // writes land only at the completing edge, so strobes act exactly once
  wire       wr_en = psel & penable & pwrite & pready;
  wire       rd_en = psel & penable & ~pwrite;
  wire       hit_ctl0 = (paddr == `OFS_COUNTER_CONTROL);
  wire       hit_ctl1 = (paddr == `OFS_IDLE_TRIG_CONTROL);
  wire       hit_ctl2 = (paddr == `OFS_CONTROL2);
  wire       hit_stat = (paddr == `OFS_IRQ_STATUS);
  wire       hit_clr  = (paddr == `OFS_IRQ_CLEAR);
  wire       hit_ien  = (paddr == `OFS_IRQ_ENABLE);
  wire       mapped = hit_ctl0 | hit_ctl1 | hit_ctl2 | hit_stat |
                      hit_clr | hit_ien;

  wire [1:0] align_cur  = ctl0_reg[`ALIGN_HI:`ALIGN_LO];
  wire [2:0] trig_sel   = ctl1_reg[`TRIG_HI:`TRIG_LO];
  wire [1:0] protect_level_lvl   = ctl2_reg[`PROTECT_LEVEL_HI:`PROTECT_LEVEL_LO];
  wire       poe        = ctl2_reg[`BIT_POE];
  wire       quad_mode  = ctl2_reg[`BIT_QUAD];
  wire       pause_mode = ctl2_reg[`BIT_PAUSE];
  wire       run        = ctl0_reg[`BIT_RUN];
  wire       inhibit    = ctl0_reg[`BIT_INHIBIT];
  wire       src_only   = ctl0_reg[`BIT_SOURCE];
  wire       single     = ctl0_reg[`BIT_SINGLE];

  // software update request is a write-one pulse needing bits 0 and 3 of control2
  wire       sw_req = wr_en & hit_ctl2 & pwdata[0] & pwdata[3];
  wire       upd_any = sw_req | overflow_event | slave_restart;
  wire       upd_ev  = ~inhibit & upd_any;
  wire       hw_dir  = (align_cur != `ALIGN_EDGE) | quad_mode;

  reg [31:0] ctl0_next;
  reg [31:0] ctl1_next;
  reg [31:0] ctl2_next;
  reg [2:0]  stat_next;
  reg [31:0] rdata_next;
  reg        trig_next;
  reg [2:0]  events;

  always @* begin
    ctl0_next = ctl0_reg;
    if (wr_en && hit_ctl0) begin
      ctl0_next = pwdata & `MASK_COUNTER_CONTROL;
      // locked alignment: stay edge-aligned once counting
      if (run && align_cur == `ALIGN_EDGE) begin
        ctl0_next[`ALIGN_HI:`ALIGN_LO] = `ALIGN_EDGE;
      end
      if (hw_dir) begin
        ctl0_next[`BIT_DIR] = ctl0_reg[`BIT_DIR];
      end
    end
    if (hw_dir) begin
      ctl0_next[`BIT_DIR] = hw_dir_down;
    end
    // the run bit falls at the update event in single pulse mode
    if (single && run && upd_ev) begin
      ctl0_next[`BIT_RUN] = 1'b0;
    end
  end

  always @* begin
    ctl1_next = ctl1_reg;
    if (wr_en && hit_ctl1) begin
      ctl1_next = (ctl1_reg & ~`MASK_IDLE_TRIG) |
                  (pwdata & `MASK_IDLE_TRIG);
      // idle levels are frozen unless protection is open
      if (protect_level_lvl != `PROTECT_LEVEL_OPEN) begin
        ctl1_next[`IDLE_HI:`IDLE_LO] = ctl1_reg[`IDLE_HI:`IDLE_LO];
      end
    end
    ctl2_next = ctl2_reg;
    if (wr_en && hit_ctl2) begin
      ctl2_next = pwdata & `MASK_CONTROL2;
    end
  end

  always @* begin
    // update interrupt: source select narrows the causes
    events = 3'h0;
    events[`IRQ_UPDATE] = ~inhibit &
      (src_only ? overflow_event : upd_any);
    events[`IRQ_TRIGGER] = slave_restart;
    events[`IRQ_STOP] = single & run & upd_ev;
    stat_next = stat_reg;
    if (wr_en && hit_clr) begin
      stat_next = stat_reg & ~pwdata[2:0];
    end
    // set wins over a clear in the same cycle
    stat_next = stat_next | events;
  end

  always @* begin
    case (trig_sel)
      `TRIG_RESET:  trig_next = sw_req | restart_d_reg;
      `TRIG_ENABLE: begin
        // pause input is retimed unless master-slave sync is set
        trig_next = run | (pause_mode & pause_trigger_in);
        if (!ctl2_reg[`BIT_SYNC]) begin
          trig_next = run | pause_d_reg;
        end
      end
      `TRIG_UPDATE: trig_next = upd_ev;
      `TRIG_CAPCMP: trig_next = chan0_capcmp_event;
      `TRIG_OC0:    trig_next = compare_ref[0];
      `TRIG_OC1:    trig_next = compare_ref[1];
      `TRIG_OC2:    trig_next = compare_ref[2];
      `TRIG_OC3:    trig_next = compare_ref[3];
      default:      trig_next = 1'b0;
    endcase
  end

  always @* begin
    rdata_next = 32'h00000000;
    if (hit_ctl0) begin
      rdata_next = ctl0_reg;
    end else if (hit_ctl1) begin
      rdata_next = ctl1_reg;
    end else if (hit_ctl2) begin
      rdata_next = ctl2_reg;
    end else if (hit_stat) begin
      rdata_next = {29'h0, stat_reg};
    end else if (hit_ien) begin
      rdata_next = {29'h0, ien_reg};
    end
  end

  wire [3:0] main_idle;
  // idle bits interleave: main at 8,10,12,14 and complement at 9,11,13
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      idle_delay u_dly (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .go_idle   (~poe),
        .has_compl (g < 3),
        .idle_now  (main_idle[g])
      );
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          chan_primary_output[g] <= 1'b0;
        end else if (main_idle[g]) begin
          chan_primary_output[g] <=
            ctl1_reg[`IDLE_LO + 2*g];
        end else begin
          chan_primary_output[g] <= chan_active_out[g];
        end
      end
      if (g < 3) begin : g_compl
        always @(posedge ref_clk or negedge rst_n) begin
          if (!rst_n) begin
            chan_complementary_output[g] <= 1'b0;
          end else if (!poe) begin
            chan_complementary_output[g] <=
              ctl1_reg[`IDLE_LO + 2*g + 1];
          end else begin
            chan_complementary_output[g] <= compl_active_out[g];
          end
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl0_reg         <= `RST_COUNTER_CONTROL;
      ctl1_reg         <= `RST_IDLE_TRIG_CONTROL;
      ctl2_reg         <= `RST_CONTROL2;
      stat_reg         <= 3'h0;
      ien_reg          <= 3'h0;
      sw_req_reg       <= 1'b0;
      restart_d_reg    <= 1'b0;
      pause_d_reg      <= 1'b0;
      prdata           <= 32'h00000000;
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      counter_run      <= 1'b0;
      count_down       <= 1'b0;
      align_mode       <= 2'h0;
      update_event     <= 1'b0;
      update_request   <= 1'b0;
      counter_reinit   <= 1'b0;
      trigger_output   <= 1'b0;
      chan0_trigger_in <= 1'b0;
      irq              <= 1'b0;
    end else begin
      ctl0_reg      <= ctl0_next;
      ctl1_reg      <= ctl1_next;
      ctl2_reg      <= ctl2_next;
      stat_reg      <= stat_next;
      if (wr_en && hit_ien) begin
        ien_reg <= pwdata[2:0];
      end
      sw_req_reg    <= sw_req;
      restart_d_reg <= slave_restart;
      pause_d_reg   <= pause_mode & pause_trigger_in;
      // one wait state: pready rises in the second access cycle
      pready        <= psel & penable & ~pready;
      pslverr       <= psel & penable & ~pready & ~mapped;
      if (rd_en && !pready) begin
        prdata <= rdata_next;
      end
      counter_run    <= ctl0_next[`BIT_RUN];
      count_down     <= ctl0_next[`BIT_DIR];
      align_mode     <= ctl0_next[`ALIGN_HI:`ALIGN_LO];
      update_event   <= upd_ev;
      update_request <= events[`IRQ_UPDATE];
      counter_reinit <= sw_req | slave_restart;
      trigger_output <= trig_next;
      chan0_trigger_in <= ctl1_reg[`BIT_TRIG_IN_SEL] ?
        (chan_pins[0] ^ chan_pins[1] ^ chan_pins[2]) :
        chan_pins[0];
      // new enable mask counts at once, so irq never lags the enable write
      irq <= |(stat_next & ((wr_en && hit_ien) ? pwdata[2:0] : ien_reg));
    end
  end
endmodule // timer_ctrl
`default_nettype wire

// >>> test/timer_ctrl_asserts.sv
// concurrent checks on the timer control block ports
`timescale 1ns/1ps
`default_nettype none
module timer_ctrl_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        overflow_event,
  input wire logic        slave_restart,
  input wire logic        chan0_capcmp_event,
  input wire logic [3:0]  compare_ref,
  input wire logic        counter_run,
  input wire logic [1:0]  align_mode,
  input wire logic        update_event,
  input wire logic        update_request,
  input wire logic        counter_reinit,
  input wire logic        trigger_output
);
  logic [2:0] mm_reg;
  logic [2:0] cc_reg;
  logic       busy;
  // shadows load at the same edge as the design registers; writes in flight are masked
  assign busy = psel && penable && pwrite;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mm_reg <= 3'h0;
      cc_reg <= 3'h0;
    end else if (busy && pready && paddr == 12'h004) begin
      mm_reg <= pwdata[6:4];
    end else if (busy && pready && paddr == 12'h000) begin
      cc_reg <= pwdata[3:1];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_lock;
    counter_run && align_mode == 2'h0 |=> align_mode == 2'h0 || !counter_run;
  endproperty
  a_lock: assert property (p_lock)
    else $error("alignment left edge mode while running");
  property p_single;
    cc_reg[2] && !cc_reg[0] && counter_run && overflow_event && !busy
      |-> ##[1:3] !counter_run;
  endproperty
  a_single: assert property (p_single)
    else $error("single pulse did not stop the counter");
  property p_src;
    update_request && cc_reg[1] && !busy |-> $past(overflow_event);
  endproperty
  a_src: assert property (p_src)
    else $error("update request without overflow");
  property p_upd;
    !cc_reg[0] && overflow_event && !busy |=> update_event;
  endproperty
  a_upd: assert property (p_upd)
    else $error("overflow gave no update event");
  property p_inh;
    cc_reg[0] && !busy |=> !update_event;
  endproperty
  a_inh: assert property (p_inh)
    else $error("update event while inhibited");
  property p_reinit;
    slave_restart |=> counter_reinit;
  endproperty
  a_reinit: assert property (p_reinit)
    else $error("restart did not reinitialize counter");
  property p_trg_upd;
    mm_reg == 3'h2 && !busy && update_event |-> ##[0:1] trigger_output;
  endproperty
  a_trg_upd: assert property (p_trg_upd)
    else $error("trigger missed the update event");
  property p_trg_cap;
    mm_reg == 3'h3 && !busy |=> trigger_output == $past(chan0_capcmp_event);
  endproperty
  a_trg_cap: assert property (p_trg_cap)
    else $error("trigger differs from channel 0 match");
  property p_trg_oc;
    mm_reg[2] && !busy |=> trigger_output == $past(compare_ref[mm_reg[1:0]]);
  endproperty
  a_trg_oc: assert property (p_trg_oc)
    else $error("trigger differs from compare reference");
  c_oc: cover property (mm_reg[2] && trigger_output);
  c_upd: cover property (update_event);
  c_reinit: cover property (counter_reinit);
endmodule // timer_ctrl_asserts
bind timer_ctrl timer_ctrl_asserts u_timer_ctrl_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .paddr(paddr), .pwdata(pwdata),
  .overflow_event(overflow_event), .slave_restart(slave_restart),
  .chan0_capcmp_event(chan0_capcmp_event), .compare_ref(compare_ref),
  .counter_run(counter_run), .align_mode(align_mode),
  .update_event(update_event), .update_request(update_request),
  .counter_reinit(counter_reinit), .trigger_output(trigger_output)
);
`default_nettype wire

// >>> test/slave_model.sv
// counter core and slave timer stand-in at the far side of the trigger
`timescale 1ns/1ps
`default_nettype none
module slave_model (
  input  wire logic ref_clk,
  input  wire logic trigger_output,
  output var  logic overflow_event,
  output var  logic slave_restart,
  output var  logic chan0_capcmp_event
);
  int   trig_cnt;
  logic last_reg;
  initial begin
    trig_cnt = 0;
    last_reg = 1'b0;
    overflow_event = 1'b0;
    slave_restart = 1'b0;
    chan0_capcmp_event = 1'b0;
  end
  // a slave acts on rising edges only, so a stuck-high trigger counts once
  always @(posedge ref_clk) begin
    last_reg <= trigger_output;
    if (trigger_output === 1'b1 && last_reg === 1'b0)
      trig_cnt <= trig_cnt + 1;
  end
  // one-cycle event: 0 wrap, 1 slave restart, 2 channel 0 match
  task automatic pulse(input int k);
    overflow_event <= (k == 0);
    slave_restart <= (k == 1);
    chan0_capcmp_event <= (k == 2);
    @(posedge ref_clk);
    overflow_event <= 1'b0;
    slave_restart <= 1'b0;
    chan0_capcmp_event <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // slave_model
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        ref_clk, rst_n, psel, penable, pwrite, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic        pause_trigger_in, hw_dir_down;
  logic [3:0]  compare_ref, chan_active_out;
  logic [2:0]  compl_active_out, chan_pins;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, trigger_output, chan0_trigger_in;
  wire         count_down;
  wire         overflow_event, slave_restart, chan0_capcmp_event;
  wire  [3:0]  chan_primary_output;
  wire  [2:0]  chan_complementary_output;
  int          err_count, num_checks, n0;
  int          evk[4] = '{1, 0, 0, 2};

  timer_ctrl u_timer_ctrl (.*, .counter_run(),
    .align_mode(), .update_event(), .update_request(), .counter_reinit());
  slave_model u_slave_model (.*);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      $display("wrong value at %0t seen %h expected %h", $time, s, e);
      err_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // request held until pready is sampled; an extra edge keeps strobes clean
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_count++;
      summarize();
    end
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pause_trigger_in = 1'b0;
    hw_dir_down = 1'b0;
    compare_ref = 4'h0;
    chan_pins = 3'h0;
    chan_active_out = 4'ha;
    compl_active_out = 3'h5;
    err_count = 0;
    num_checks = 0;
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    rd(12'h000, 32'h0);
    rd(12'h040, 32'h0);
    chk(serr, 1'b1);
    wr(12'h004, 32'hffffffff);
    rd(12'h004, 32'h00007ff0);
    wr(12'h004, 32'h00002a00);
    tick(5);
    chk({chan_primary_output, chan_complementary_output}, 7'h07);
    wr(12'h008, 32'h1);
    tick(2);
    chk({chan_primary_output, chan_complementary_output}, 7'h55);
    wr(12'h004, 32'h00005500);
    wr(12'h008, 32'h0);
    tick(5);
    chk({chan_primary_output, chan_complementary_output}, 7'h78);
    $display("test 1 done");
    for (int a = 0; a < 4; a++) begin
      hw_dir_down <= (a == 2);
      wr(12'h000, 32'h10 | (a << 5));
      rd(12'h000, (a << 5) | (a % 2 == 0 ? 32'h10 : 32'h0));
      chk(count_down, a % 2 == 0);
    end
    wr(12'h000, 32'h1);
    wr(12'h000, 32'h21);
    rd(12'h000, 32'h1);
    wr(12'h000, 32'h0);
    $display("test 2 done");
    n0 = u_slave_model.trig_cnt;
    wr(12'h004, 32'h0);
    wr(12'h008, 32'h9);
    tick(2);
    chk(u_slave_model.trig_cnt, n0 + 1);
    for (int m = 0; m < 4; m++) begin
      wr(12'h004, m << 4);
      n0 = u_slave_model.trig_cnt;
      if (m == 1)
        wr(12'h000, 32'h1);
      else
        u_slave_model.pulse(evk[m]);
      tick(3);
      chk(u_slave_model.trig_cnt, n0 + 1);
      if (m == 1)
        wr(12'h000, 32'h0);
    end
    wr(12'h004, 32'h10);
    wr(12'h008, 32'h80);
    pause_trigger_in <= 1'b1;
    tick(3);
    chk(trigger_output, 1'b1);
    wr(12'h008, 32'h02);
    tick(3);
    chk(trigger_output, 1'b0);
    wr(12'h008, 32'h82);
    tick(1);
    chk(trigger_output, 1'b1);
    pause_trigger_in <= 1'b0;
    tick(3);
    chk(trigger_output, 1'b0);
    for (int m = 4; m < 8; m++) begin
      wr(12'h004, m << 4);
      compare_ref <= 4'h1 << (m - 4);
      tick(3);
      chk(trigger_output, 1'b1);
      compare_ref <= ~(4'h1 << (m - 4));
      tick(3);
      chk(trigger_output, 1'b0);
    end
    $display("test 3 done");
    wr(12'h014, 32'h7);
    wr(12'h010, 32'h7);
    wr(12'h008, 32'h9);
    rd(12'h00c, 32'h1);
    chk(irq, 1'b1);
    wr(12'h010, 32'h7);
    chk(irq, 1'b0);
    u_slave_model.pulse(1);
    rd(12'h00c, 32'h3);
    wr(12'h010, 32'h7);
    wr(12'h000, 32'h4);
    wr(12'h008, 32'h9);
    u_slave_model.pulse(1);
    rd(12'h00c, 32'h2);
    u_slave_model.pulse(0);
    rd(12'h00c, 32'h3);
    wr(12'h014, 32'h4);
    chk(irq, 1'b0);
    wr(12'h010, 32'h7);
    wr(12'h000, 32'h2);
    u_slave_model.pulse(0);
    rd(12'h00c, 32'h0);
    wr(12'h000, 32'h9);
    u_slave_model.pulse(0);
    rd(12'h000, 32'h8);
    rd(12'h00c, 32'h5);
    chk(irq, 1'b1);
    $display("test 4 done");
    wr(12'h004, 32'h80);
    chan_pins <= 3'h3;
    tick(3);
    chk(chan0_trigger_in, 1'b0);
    chan_pins <= 3'h7;
    tick(3);
    chk(chan0_trigger_in, 1'b1);
    wr(12'h004, 32'h0);
    chan_pins <= 3'h6;
    tick(3);
    chk(chan0_trigger_in, 1'b0);
    wr(12'h004, 32'h5500);
    wr(12'h008, 32'h10);
    wr(12'h004, 32'h2a30);
    rd(12'h004, 32'h5530);
    chk({chan_primary_output, chan_complementary_output}, 7'h78);
    $display("test 5 done");
    summarize();
  end
endmodule // tb_top
`default_nettype wire
